// ### inc/nvs_host_consts.svh
// Purpose: timing constants for the nonvolatile sram host controller
// Assumes: 125 MHz clock, 8 ns period
// Notes: times in ns as printed (restore time in us), cycle counts derived from them
`ifndef NVS_HOST_CONSTS_SVH
`define NVS_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 8
// least times round up, longest times round down
`define RC_MIN_NS 45
`define RC_CYC ((`RC_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWE_MIN_NS 30
`define PWE_CYC ((`PWE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HW_SAVE_PULSE_MIN_NS 15
`define HW_SAVE_PULSE_CYC \
   ((`HW_SAVE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HW_SAVE_BUSY_DELAY_NS 300
`define HW_SAVE_BUSY_CYC (`HW_SAVE_BUSY_DELAY_NS / `CLK_PERIOD_NS)
`define INHIBIT_RELEASE_DELAY_NS 700
`define INHIBIT_RELEASE_CYC \
   (`INHIBIT_RELEASE_DELAY_NS / `CLK_PERIOD_NS)
`define POWERUP_RESTORE_TIME_US 550
`define POWERUP_RESTORE_CYC \
   (`POWERUP_RESTORE_TIME_US * 1000 / `CLK_PERIOD_NS)
`define SW_SEQ_LEN 6
`define CNT_W 17
`endif

// ### inc/nvs_host_pkg.sv
// Purpose: types for the nonvolatile sram host controller
// Assumes: nothing
// Notes: one-hot state codes
package nvs_host_pkg;
   typedef enum logic [7:0] {
      ST_BOOT  = 8'h01,
      ST_IDLE  = 8'h02,
      ST_SETUP = 8'h04,
      ST_STRB  = 8'h08,
      ST_GAP   = 8'h10,
      ST_HWPLS = 8'h20,
      ST_HWBSY = 8'h40,
      ST_HWREC = 8'h80
   } state_t;
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_SWSEQ = 2'h2,
      OP_HWSAVE = 2'h3
   } op_t;
endpackage

// ### src/nvs_pin_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to CLK
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module nvs_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ### src/nvs_host_ctrl.sv
// Purpose: host-side controller driving a 32K x 8 sram with nv shadow
// Assumes: 125 MHz CLK, device pins asynchronous, slowest speed grade
// Notes: one request at a time; busy line is open drain
`timescale 1ns/1ns
`include "nvs_host_consts.svh"
module nvs_host_ctrl #(
   parameter int AW = 15,
   parameter int DW = 8,
   parameter int RESTORE_CYC = `POWERUP_RESTORE_CYC,
   parameter logic [6*AW-1:0] SEQ_ADDRS = '0
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // user request
   input wire logic REQ_VALID,
   input wire nvs_host_pkg::op_t REQ_OP,
   input wire logic [AW-1:0] REQ_ADDR,
   input wire logic [DW-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [DW-1:0] RSP_RDATA,
   // device pins
   output logic [AW-1:0] MEM_ADDR,
   output logic CHIP_SEL_N,
   output logic OUT_EN_N,
   output logic WRITE_EN_N,
   input wire logic [DW-1:0] DQ_IN,
   output logic [DW-1:0] DQ_OUT,
   output logic DQ_OE,
   input wire logic STORE_BUSY_LINE_N_IN,
   output logic STORE_BUSY_LINE_N_OE
);
   nvs_host_pkg::state_t st_q, st_d;
   logic [`CNT_W-1:0] cnt_q, cnt_d;
   logic [2:0] step_q, step_d;
   nvs_host_pkg::op_t op_q;
   logic [DW-1:0] dq_s;
   logic busy_s;
   logic cnt_done, seq_last, take;
   logic [AW-1:0] seq_addr;

   // -----------------------------------------
   // pin synchronisers
   // -----------------------------------------
   nvs_pin_sync #(.W(DW + 1)) u_sync (
      .clk(CLK),
      .rst_n(RSTN),
      .async_in({STORE_BUSY_LINE_N_IN, DQ_IN}),
      .sync_out({busy_s, dq_s})
   );

   function automatic logic [AW-1:0] seq_at(input logic [2:0] i);
      seq_at = SEQ_ADDRS[i*AW +: AW];
   endfunction

   // -----------------------------------------
   // decode
   // -----------------------------------------
   assign cnt_done = (cnt_q == '0);
   assign seq_last = (step_q == 3'(`SW_SEQ_LEN - 1));
   assign seq_addr = seq_at(step_q + 3'h1);
   // device holds off while busy line low, so do we
   assign take = REQ_VALID && REQ_READY && busy_s;

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
      step_d = step_q;
      unique case (st_q)
         nvs_host_pkg::ST_BOOT:
            // first cycle after reset loads the restore wait
            if (step_q == '0)
               cnt_d = `CNT_W'(RESTORE_CYC);
            else if (cnt_done && busy_s)
               st_d = nvs_host_pkg::ST_IDLE;
         nvs_host_pkg::ST_IDLE:
            if (take)
            begin
               step_d = '0;
               if (REQ_OP == nvs_host_pkg::OP_HWSAVE)
               begin
                  st_d = nvs_host_pkg::ST_HWPLS;
                  cnt_d = `CNT_W'(`HW_SAVE_PULSE_CYC);
               end
               else
               begin
                  st_d = nvs_host_pkg::ST_SETUP;
                  cnt_d = '0;
               end
            end
         nvs_host_pkg::ST_SETUP:
         begin
            st_d = nvs_host_pkg::ST_STRB;
            cnt_d = `CNT_W'(`RC_CYC - 1);
         end
         nvs_host_pkg::ST_STRB:
            if (cnt_done)
               st_d = nvs_host_pkg::ST_GAP;
         nvs_host_pkg::ST_GAP:
            if (op_q == nvs_host_pkg::OP_SWSEQ && !seq_last)
            begin
               step_d = step_q + 3'h1;
               st_d = nvs_host_pkg::ST_SETUP;
            end
            else
               st_d = nvs_host_pkg::ST_IDLE;
         nvs_host_pkg::ST_HWPLS:
            if (cnt_done)
            begin
               st_d = nvs_host_pkg::ST_HWBSY;
               cnt_d = `CNT_W'(`HW_SAVE_BUSY_CYC + 2);
            end
         nvs_host_pkg::ST_HWBSY:
            // no save needed: line never goes low, give up after wait
            if (busy_s && cnt_done)
            begin
               st_d = nvs_host_pkg::ST_HWREC;
               cnt_d = `CNT_W'(`INHIBIT_RELEASE_CYC + 1);
            end
            // our own pulse echoes through the synchroniser at first
            else if (!busy_s && cnt_q <= `CNT_W'(`HW_SAVE_BUSY_CYC))
               cnt_d = '0;
         nvs_host_pkg::ST_HWREC:
            // recovery timed only once the save has ended
            if (!busy_s)
               st_d = nvs_host_pkg::ST_HWBSY;
            else if (cnt_done)
               st_d = nvs_host_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_q <= nvs_host_pkg::ST_BOOT;
         cnt_q <= '0;
         step_q <= '0;
         op_q <= nvs_host_pkg::OP_READ;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         step_q <= (st_q == nvs_host_pkg::ST_BOOT) ? 3'h1 : step_d;
         if (take)
            op_q <= REQ_OP;
      end
   end

   // -----------------------------------------
   // pin drive
   // -----------------------------------------
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         MEM_ADDR <= '0;
         CHIP_SEL_N <= 1'b1;
         OUT_EN_N <= 1'b1;
         WRITE_EN_N <= 1'b1;
         DQ_OUT <= '0;
         DQ_OE <= 1'b0;
         STORE_BUSY_LINE_N_OE <= 1'b0;
         REQ_READY <= 1'b0;
         RSP_VALID <= 1'b0;
         RSP_RDATA <= '0;
      end
      else
      begin
         // ready drops while the device holds the busy line low
         REQ_READY <= (st_d == nvs_host_pkg::ST_IDLE) && busy_s;
         RSP_VALID <= 1'b0;
         // address moves only with select high
         if (take)
            MEM_ADDR <= (REQ_OP == nvs_host_pkg::OP_SWSEQ) ?
                        seq_at(3'h0) : REQ_ADDR;
         else if (st_q == nvs_host_pkg::ST_GAP && st_d ==
                  nvs_host_pkg::ST_SETUP)
            MEM_ADDR <= seq_addr;
         if (take && REQ_OP == nvs_host_pkg::OP_WRITE)
            DQ_OUT <= REQ_WDATA;
         // one select fall per step, so no double clock
         CHIP_SEL_N <= (st_d != nvs_host_pkg::ST_STRB);
         OUT_EN_N <= !(st_d == nvs_host_pkg::ST_STRB &&
                       op_q != nvs_host_pkg::OP_WRITE);
         // strobe low only after select, high in reads and sequence
         WRITE_EN_N <= !(st_d == nvs_host_pkg::ST_STRB &&
                         op_q == nvs_host_pkg::OP_WRITE &&
                         st_q == nvs_host_pkg::ST_STRB);
         DQ_OE <= (st_d == nvs_host_pkg::ST_STRB &&
                   op_q == nvs_host_pkg::OP_WRITE);
         // busy line driven only for the hardware save pulse
         STORE_BUSY_LINE_N_OE <= (st_d == nvs_host_pkg::ST_HWPLS);
         if (st_q == nvs_host_pkg::ST_GAP &&
             op_q != nvs_host_pkg::OP_WRITE)
         begin
            RSP_RDATA <= dq_s;
         end
         if (st_q == nvs_host_pkg::ST_GAP &&
             st_d == nvs_host_pkg::ST_IDLE)
            RSP_VALID <= 1'b1;
      end
   end

   // -----------------------------------------
   // checks
   // -----------------------------------------
   a_read_we_high: assert property (@(posedge CLK) disable iff (!RSTN)
      (!CHIP_SEL_N && op_q != nvs_host_pkg::OP_WRITE) |->
      (WRITE_EN_N && !STORE_BUSY_LINE_N_OE))
      else $error("write strobe or busy low in read");
   a_write_no_busy: assert property (@(posedge CLK) disable iff (!RSTN)
      !CHIP_SEL_N |-> !STORE_BUSY_LINE_N_OE)
      else $error("busy line driven during access");
   a_addr_stable: assert property (@(posedge CLK) disable iff (!RSTN)
      $changed(MEM_ADDR) |-> (CHIP_SEL_N || WRITE_EN_N))
      else $error("address moved while selected and writing");
   a_step_width: assert property (@(posedge CLK) disable iff (!RSTN)
      $fell(CHIP_SEL_N) |-> !CHIP_SEL_N [*6])
      else $error("select step shorter than cycle time");
   a_hw_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
      $rose(STORE_BUSY_LINE_N_OE) |-> STORE_BUSY_LINE_N_OE [*2])
      else $error("hardware save pulse too short");
   a_busy_wait: assert property (@(posedge CLK) disable iff (!RSTN)
      (!busy_s && st_q != nvs_host_pkg::ST_HWPLS) |-> !take)
      else $error("request taken while device busy");
   a_seq_we: assert property (@(posedge CLK) disable iff (!RSTN)
      (op_q == nvs_host_pkg::OP_SWSEQ && !CHIP_SEL_N) |-> WRITE_EN_N)
      else $error("write strobe low in command sequence");
   a_rec_wait: assert property (@(posedge CLK) disable iff (!RSTN)
      (st_q == nvs_host_pkg::ST_HWREC && $past(st_q) ==
       nvs_host_pkg::ST_HWBSY) |-> $past(busy_s))
      else $error("recovery began before save ended");
endmodule

// ### testbench/nvs_dev_model.sv
// Purpose: behavioural model of the nv sram on the controller's pins
// Assumes: clk paces the device's own delays and samples writes
// Notes: undriven data shows a pattern that toggles each cycle
`timescale 1ns/1ns
module nvs_dev_model #(
   parameter logic [89:0] SEQ = '0
) (
   // clock
   input wire logic clk,
   // device pins
   input wire logic [14:0] addr,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   input wire logic line_n,
   output logic pull,
   // supply monitor
   input wire logic pwr_fail,
   // observation
   output int fires
);
   logic [7:0] mem [0:32767];
   logic wfirst = 1'b0;
   logic dirty = 1'b0;
   logic pf_q = 1'b0;
   logic [7:0] rel_q = 8'h5a;
   int step = 0;
   int cnt = 0;
   // no output while busy or when write came first
   wire drv = !cs_n && !oe_n && we_n && !wfirst && !pull;
   assign dout = drv ? mem[addr] : rel_q;
   initial pull = 1'b0;
   initial fires = 0;
   always @(posedge cs_n)
      wfirst = 1'b0;
   always @(negedge cs_n)
   begin
      wfirst = !we_n;
      if (!we_n)
         step = 0;
      else if (addr == SEQ[15*step +: 15])
         step = step + 1;
      else
         // a mismatched fall at the first sequence address restarts the sequence
         step = (addr == SEQ[14:0]) ? 1 : 0;
      if (step == 6)
      begin
         step = 0;
         fires = fires + 1;
      end
   end
   // inhibit ends with the save itself, so recovery is instant
   // writes sampled on the clock, so a shared end of cycle cannot race
   always @(posedge clk)
   begin
      rel_q <= ~rel_q;
      pf_q <= pwr_fail;
      if (!cs_n && !we_n)
      begin
         mem[addr] <= din;
         dirty <= 1'b1;
      end
      // save on a store pulse, or on supply loss with a write pending
      if (cnt == 0 && !pull && (!line_n || (pwr_fail && !pf_q && dirty)))
         cnt <= 1;
      else if (cnt > 0)
         cnt <= cnt + 1;
      if (cnt == 10)
      begin
         pull <= 1'b1;
         dirty <= 1'b0;
      end
      // busy held for about a microsecond
      if (cnt == 135)
      begin
         pull <= 1'b0;
         cnt <= 0;
      end
   end
endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench for the nv sram host controller
// Assumes: short restore count in simulation
// Notes: outputs are sampled at the falling edge
`timescale 1ns/1ns
`include "nvs_host_consts.svh"
module tb;
   localparam int RC = 20;
   localparam logic [89:0] SEQ = {15'h4c63, 15'h3b1c, 15'h0fc0,
      15'h703f, 15'h31c7, 15'h0e38};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic vld = 1'b0;
   logic pf = 1'b0;
   nvs_host_pkg::op_t op_r = nvs_host_pkg::OP_READ;
   logic [14:0] adr = 15'h0000;
   logic [7:0] wd = 8'h00;
   logic rdy, rsp_v, cs_n, oe_n, we_n, dq_oe, bsy_oe, pull;
   logic [7:0] rdata, dq_out, dev_dq;
   logic [14:0] maddr;
   int fires, fail_count = 0, checked = 0;
   // open-drain busy line with pull-up
   wire line_n = !(bsy_oe || pull);
   wire [7:0] dq = dq_oe ? dq_out : dev_dq;
   nvs_host_ctrl #(.RESTORE_CYC(RC), .SEQ_ADDRS(SEQ)) dut_u (
      .CLK(clk), .RSTN(rst_n), .REQ_VALID(vld), .REQ_OP(op_r),
      .REQ_ADDR(adr), .REQ_WDATA(wd), .REQ_READY(rdy),
      .RSP_VALID(rsp_v), .RSP_RDATA(rdata), .MEM_ADDR(maddr),
      .CHIP_SEL_N(cs_n), .OUT_EN_N(oe_n), .WRITE_EN_N(we_n),
      .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .STORE_BUSY_LINE_N_IN(line_n), .STORE_BUSY_LINE_N_OE(bsy_oe));
   nvs_dev_model #(.SEQ(SEQ)) dev_u (
      .clk(clk), .addr(maddr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
      .din(dq), .dout(dev_dq), .line_n(line_n), .pull(pull),
      .pwr_fail(pf), .fires(fires));
   initial
      forever #4 clk = ~clk;
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic issue(input nvs_host_pkg::op_t o, input logic [14:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      chk(rdy, "ready never rose");
      vld = 1'b1;
      op_r = o;
      adr = a;
      wd = d;
      @(negedge clk);
      vld = 1'b0;
   endtask
   task automatic wait_rsp();
      int n;
      n = 0;
      while (rsp_v !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      chk(rsp_v, "no response");
   endtask
   task automatic t_boot();
      repeat (RC - 2) @(negedge clk);
      chk(rdy === 1'b0, "ready before restore");
      repeat (30) @(negedge clk);
      chk(rdy === 1'b1, "ready late after restore");
   endtask
   // back-to-back writes at the top of memory, then read back
   task automatic t_rw();
      for (int k = 0; k < 6; k++)
      begin
         issue(k < 3 ? nvs_host_pkg::OP_WRITE : nvs_host_pkg::OP_READ,
            15'h7ffd + 15'(k % 3), 8'hc3 + 8'(17 * (k % 3)));
         wait_rsp();
         if (k > 2)
            chk(rdata === 8'hc3 + 8'(17 * (k % 3)), "read data");
      end
      chk(dq_oe === 1'b0 && we_n === 1'b1, "pins idle");
   endtask
   task automatic t_sw();
      int f;
      f = fires;
      issue(nvs_host_pkg::OP_SWSEQ, 15'h0000, 8'h00);
      wait_rsp();
      chk(fires == f + 1, "sequence not seen");
   endtask
   task automatic t_hw();
      int p, r;
      logic lo, bad;
      p = 0;
      r = 0;
      lo = 1'b0;
      bad = 1'b0;
      issue(nvs_host_pkg::OP_HWSAVE, 15'h0000, 8'h00);
      for (int n = 0; n < 600 && rdy !== 1'b1; n++)
      begin
         @(negedge clk);
         p += int'(bsy_oe);
         lo |= pull;
         r += int'(lo && line_n);
         bad |= !cs_n;
      end
      chk(p >= `HW_SAVE_PULSE_CYC, "save pulse short");
      chk(lo, "device never busy");
      chk(r >= `INHIBIT_RELEASE_CYC, "recovery short");
      chk(!bad && rdy === 1'b1, "access during save");
   endtask
   // supply loss: no save when clean, save and held-off read when dirty
   task automatic t_pf();
      logic lo, held;
      lo = 1'b0;
      pf = 1'b1;
      repeat (20)
      begin
         @(negedge clk);
         lo |= pull;
      end
      pf = 1'b0;
      chk(!lo && rdy === 1'b1, "save without write");
      issue(nvs_host_pkg::OP_WRITE, 15'h0042, 8'h3c);
      wait_rsp();
      pf = 1'b1;
      repeat (16) @(negedge clk);
      chk(pull === 1'b1 && rdy === 1'b0, "no auto save");
      pf = 1'b0;
      held = pull;
      issue(nvs_host_pkg::OP_READ, 15'h0042, 8'h00);
      wait_rsp();
      chk(held && !pull && rdata === 8'h3c, "read not held off");
   endtask
   task automatic t_rst();
      issue(nvs_host_pkg::OP_WRITE, 15'h0123, 8'ha5);
      rst_n = 1'b0;
      @(negedge clk);
      chk(cs_n === 1'b1 && dq_oe === 1'b0 && rdy === 1'b0, "reset pins");
      rst_n = 1'b1;
      t_boot();
      issue(nvs_host_pkg::OP_READ, 15'h7ffe, 8'h00);
      wait_rsp();
      chk(rdata === 8'hd4, "data lost over reset");
   endtask
   initial
   begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_boot();
      t_rw();
      t_sw();
      t_hw();
      t_pf();
      t_rst();
      stop_test();
   end
   // whole run is under a thousand cycles
   initial
   begin
      #200000;
      fail_count++;
      stop_test();
   end
endmodule
